//--- rtl/ilbw_map.svh
`ifndef ILBW_MAP_SVH
`define ILBW_MAP_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ILBW_IDX_HW_PEND 9'h006
`define ILBW_IDX_RT_PEND 9'h009
`define ILBW_IDX_CNT_PTR 9'h00A
`define ILBW_IDX_HW_EN 9'h00F
`define ILBW_IDX_HW_OE 9'h013
`define ILBW_IDX_RT_EN 9'h040
`define ILBW_IDX_RT_OE 9'h041
`define ILBW_IDX_EXT_CFG 9'h04D

// ----------------------------------------------------------------------------
// Log region in RAM
// ----------------------------------------------------------------------------
`define ILBW_LOG_BASE 9'h180
`define ILBW_LOG_LAST 9'h1BF
`define ILBW_LOG_TOP_BITS 3'b110
`define ILBW_LOG_ENTRIES_LOG2 5
`define ILBW_LOG_WORDS_LOG2 6

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define ILBW_CFG_BUSY_OPT_BIT 2
`define ILBW_ID_WAS_BUSY_BIT 9
`define ILBW_HW_RT_SUMMARY_BIT 2
`define ILBW_COUNT_MAX 7'h7F
`define ILBW_HW_LOCATION_WORD 16'h0000
`define ILBW_RST_WORD 16'h0000
`define ILBW_RST_COUNT 7'h00
`define ILBW_RST_ENTRY 5'h00

`endif

//--- rtl/ilbw_pkg.sv
package ilbw_pkg;

   // -------------------------------------------------------------------------
   // Writer sequence
   // -------------------------------------------------------------------------
   typedef enum logic [0:0] {
      ILBW_WR_IDLE = 1'b0,
      ILBW_WR_SECOND = 1'b1
   } ilbw_wr_state_t;

   // -------------------------------------------------------------------------
   // Whole state of the writer block
   // -------------------------------------------------------------------------
   typedef struct packed {
      ilbw_wr_state_t wr_state;
      logic [4:0] entry_idx;
      logic [6:0] event_count;
      logic [15:0] hw_pend;
      logic [15:0] rt_pend;
      logic [15:0] hw_en;
      logic [15:0] hw_oe;
      logic [15:0] rt_en;
      logic [15:0] rt_oe;
      logic [15:0] ext_cfg;
      logic [15:0] hw_hold;
      logic [15:0] rt_hold_id;
      logic [15:0] rt_hold_addr;
      logic [15:0] cur_location;
      logic ack;
      logic ack_ram;
      logic [15:0] rd_word;
      logic irq;
   } ilbw_state_t;

   // -------------------------------------------------------------------------
   // One log RAM write
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [15:0] data;
   } ilbw_ram_wr_t;

endpackage

//--- rtl/ilbw_log_ram.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Log word store, one write port and one registered read port
// ----------------------------------------------------------------------------
module ilbw_log_ram #(
   parameter int ADDR_W = 6,
   parameter int DATA_W = 16
) (
   // Clock
   input wire logic clock,
   // Write side
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [DATA_W-1:0] wdata,
   // Read side
   input wire logic [ADDR_W-1:0] raddr,
   output logic [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Contents are not reset; software only trusts words below the pointer.
   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // ilbw_log_ram

`default_nettype wire

//--- rtl/ilbw_top.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ilbw_map.svh"

// Function
// - Sixty-four RAM words at 0x0180 to 0x01BF hold only log entries.
// - Each enabled occurrence writes exactly two words; region keeps last 32.
// - After each 32nd entry the 9-bit pointer returns to 0x0180.
// - Identification word at even address, location word next; first at 0x0180.
// - Identification word uses the layout of its class pending register.
// - Several event bits may be set together in one identification word.
// - Hardware entries write an all-zero location word.
// - Terminal entries write the descriptor entry start address of the message.
// - With busy option bit 2 set, bit 9 flags terminal was busy.
// - Busy state alone never makes a log entry or an interrupt request.
// - Several events in one message make one two-word entry.
// - Simultaneous output-enabled events are ORed onto one interrupt request.
// - Master reset or terminal soft reset sets the pointer to 0x0180.
// - Pointer advances by two per entry; after entry 32 it is reloaded.
// - Seven-bit count in bits 15:9 increments, saturates at 127, clears on read.
// - Reading hardware pending returns contents then clears it; summary bit 2 stays set while terminal pending is nonzero.
// - Setting an enable bit never logs events from while it was zero.
module ilbw_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic soft_reset,
   // Event sources
   input wire logic [15:0] hw_event,
   input wire logic [15:0] rt_event,
   input wire logic [15:0] rt_desc_addr,
   input wire logic term_busy,
   // Avalon-MM slave
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Host interrupt request
   output logic irq_n
);

   // -------------------------------------------------------------------------
   // Decoding helpers
   // -------------------------------------------------------------------------

   // Word index of a byte address; misaligned addresses map to nothing.
   function automatic logic [8:0] word_index(input logic [10:0] addr);
      word_index = addr[10:2];
   endfunction

   function automatic logic in_log_region(input logic [10:0] addr);
      in_log_region = (addr[1:0] == 2'b00) && (word_index(addr) >= `ILBW_LOG_BASE) &&
                      (word_index(addr) <= `ILBW_LOG_LAST);
   endfunction

   function automatic logic is_reg(input logic [10:0] addr, input logic [8:0] idx);
      is_reg = (addr[1:0] == 2'b00) && (word_index(addr) == idx);
   endfunction

   // Merges the two low byte lanes of a write into a 16-bit register.
   function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                              input logic [31:0] wdata,
                                              input logic [3:0] be);
      lane_merge[7:0] = be[0] ? wdata[7:0] : old_val[7:0];
      lane_merge[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   ilbw_pkg::ilbw_state_t st_reg;
   ilbw_pkg::ilbw_state_t st_next;
   ilbw_pkg::ilbw_ram_wr_t ram_wr;
   logic [5:0] ram_raddr;
   logic [15:0] ram_rdata;

   logic host_req;
   logic accept;
   logic start;
   logic rd_hw_pend;
   logic rd_rt_pend;
   logic rd_cnt_ptr;
   logic [15:0] hw_new;
   logic [15:0] rt_new;
   logic [15:0] rt_id_new;
   logic [15:0] hw_pend_view;
   logic [15:0] hw_hold_base;
   logic [15:0] rt_hold_base;
   logic [8:0] log_pointer;
   logic count_inc;

   // -------------------------------------------------------------------------
   // Log word store
   // -------------------------------------------------------------------------
   ilbw_log_ram #(
      .ADDR_W(`ILBW_LOG_WORDS_LOG2),
      .DATA_W(16)
   ) u_log_ram (
      .clock(clock),
      .we(ram_wr.we),
      .waddr(ram_wr.addr),
      .wdata(ram_wr.data),
      .raddr(ram_raddr),
      .rdata(ram_rdata)
   );

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      ram_wr = '0;
      ram_raddr = avs_address[7:2];

      // The upper pointer bits are fixed, so the pointer only walks the log.
      log_pointer = {`ILBW_LOG_TOP_BITS, st_reg.entry_idx, 1'b0};

      // The hardware summary bit mirrors the terminal pending register.
      hw_pend_view = st_reg.hw_pend;
      hw_pend_view[`ILBW_HW_RT_SUMMARY_BIT] = |st_reg.rt_pend;

      // Host side: one cycle of wait, two while the second log word is written, then the answer cycle.
      host_req = (avs_read || avs_write) && !st_reg.ack;
      // Accepting only while idle keeps a two-word update out of sight.
      accept = host_req && (st_reg.wr_state == ilbw_pkg::ILBW_WR_IDLE);
      st_next.ack = accept;
      rd_hw_pend = accept && avs_read && is_reg(avs_address, `ILBW_IDX_HW_PEND);
      rd_rt_pend = accept && avs_read && is_reg(avs_address, `ILBW_IDX_RT_PEND);
      rd_cnt_ptr = accept && avs_read && is_reg(avs_address, `ILBW_IDX_CNT_PTR);

      if (accept) begin
         st_next.ack_ram = in_log_region(avs_address);
         st_next.rd_word = `ILBW_RST_WORD;
         if (is_reg(avs_address, `ILBW_IDX_HW_PEND)) begin
            st_next.rd_word = hw_pend_view;
         end else if (is_reg(avs_address, `ILBW_IDX_RT_PEND)) begin
            st_next.rd_word = st_reg.rt_pend;
         end else if (is_reg(avs_address, `ILBW_IDX_CNT_PTR)) begin
            st_next.rd_word = {st_reg.event_count, log_pointer};
         end else if (is_reg(avs_address, `ILBW_IDX_HW_EN)) begin
            st_next.rd_word = st_reg.hw_en;
         end else if (is_reg(avs_address, `ILBW_IDX_HW_OE)) begin
            st_next.rd_word = st_reg.hw_oe;
         end else if (is_reg(avs_address, `ILBW_IDX_RT_EN)) begin
            st_next.rd_word = st_reg.rt_en;
         end else if (is_reg(avs_address, `ILBW_IDX_RT_OE)) begin
            st_next.rd_word = st_reg.rt_oe;
         end else if (is_reg(avs_address, `ILBW_IDX_EXT_CFG)) begin
            st_next.rd_word = st_reg.ext_cfg;
         end
      end

      // Writes take effect at the edge that ends the answer cycle.
      if (st_reg.ack && avs_write) begin
         if (is_reg(avs_address, `ILBW_IDX_HW_EN)) begin
            st_next.hw_en = lane_merge(st_reg.hw_en, avs_writedata, avs_byteenable);
         end
         if (is_reg(avs_address, `ILBW_IDX_HW_OE)) begin
            st_next.hw_oe = lane_merge(st_reg.hw_oe, avs_writedata, avs_byteenable);
         end
         if (is_reg(avs_address, `ILBW_IDX_RT_EN)) begin
            st_next.rt_en = lane_merge(st_reg.rt_en, avs_writedata, avs_byteenable);
         end
         if (is_reg(avs_address, `ILBW_IDX_RT_OE)) begin
            st_next.rt_oe = lane_merge(st_reg.rt_oe, avs_writedata, avs_byteenable);
         end
         if (is_reg(avs_address, `ILBW_IDX_EXT_CFG)) begin
            st_next.ext_cfg = lane_merge(st_reg.ext_cfg, avs_writedata, avs_byteenable);
         end
      end

      // Only events seen while their enable is already set are kept.
      hw_new = hw_event & st_reg.hw_en;
      hw_new[`ILBW_HW_RT_SUMMARY_BIT] = 1'b0;
      rt_new = rt_event & st_reg.rt_en;

      // Busy only decorates a real terminal event, never stands alone.
      rt_id_new = rt_new;
      if (st_reg.ext_cfg[`ILBW_CFG_BUSY_OPT_BIT] && term_busy && (|rt_new)) begin
         rt_id_new[`ILBW_ID_WAS_BUSY_BIT] = 1'b1;
      end

      // Pending registers: a new event in the clearing cycle survives.
      st_next.hw_pend = (rd_hw_pend ? `ILBW_RST_WORD : st_reg.hw_pend) | hw_new;
      st_next.rt_pend = (rd_rt_pend ? `ILBW_RST_WORD : st_reg.rt_pend) | rt_new;

      // Entry launch: hardware first when both classes wait.
      start = (st_reg.wr_state == ilbw_pkg::ILBW_WR_IDLE) && !accept &&
              ((|st_reg.hw_hold) || (|st_reg.rt_hold_id));
      hw_hold_base = st_reg.hw_hold;
      rt_hold_base = st_reg.rt_hold_id;
      count_inc = 1'b0;

      unique case (st_reg.wr_state)
         ilbw_pkg::ILBW_WR_IDLE: begin
            if (start) begin
               ram_wr.we = 1'b1;
               ram_wr.addr = {st_reg.entry_idx, 1'b0};
               st_next.wr_state = ilbw_pkg::ILBW_WR_SECOND;
               if (|st_reg.hw_hold) begin
                  ram_wr.data = st_reg.hw_hold;
                  st_next.cur_location = `ILBW_HW_LOCATION_WORD;
                  hw_hold_base = `ILBW_RST_WORD;
               end else begin
                  ram_wr.data = st_reg.rt_hold_id;
                  st_next.cur_location = st_reg.rt_hold_addr;
                  rt_hold_base = `ILBW_RST_WORD;
               end
            end
         end
         ilbw_pkg::ILBW_WR_SECOND: begin
            ram_wr.we = 1'b1;
            ram_wr.addr = {st_reg.entry_idx, 1'b1};
            ram_wr.data = st_reg.cur_location;
            // The index is five bits wide, so entry 32 wraps it to zero.
            st_next.entry_idx = st_reg.entry_idx + 5'h01;
            st_next.wr_state = ilbw_pkg::ILBW_WR_IDLE;
            count_inc = 1'b1;
         end
      endcase

      // Events of one class raised together, or while waiting, merge into one entry.
      st_next.hw_hold = hw_hold_base | hw_new;
      st_next.rt_hold_id = rt_hold_base | rt_id_new;
      if ((rt_hold_base == `ILBW_RST_WORD) && (|rt_new)) begin
         st_next.rt_hold_addr = rt_desc_addr;
      end

      // Count: an entry finished in the read cycle is counted after the clear.
      st_next.event_count = rd_cnt_ptr ? `ILBW_RST_COUNT : st_reg.event_count;
      if (count_inc && (st_next.event_count != `ILBW_COUNT_MAX)) begin
         st_next.event_count = st_next.event_count + 7'h01;
      end

      // One shared request line for every output-enabled pending event.
      st_next.irq = (|(st_next.hw_pend & st_reg.hw_oe)) ||
                    (|(st_next.rt_pend & st_reg.rt_oe));

      // Soft reset restarts the log; an entry in flight is dropped whole.
      if (soft_reset) begin
         st_next.entry_idx = `ILBW_RST_ENTRY;
         st_next.event_count = `ILBW_RST_COUNT;
         st_next.wr_state = ilbw_pkg::ILBW_WR_IDLE;
         st_next.hw_hold = `ILBW_RST_WORD;
         st_next.rt_hold_id = `ILBW_RST_WORD;
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
   assign avs_readdata = {16'h0000, (st_reg.ack_ram ? ram_rdata : st_reg.rd_word)};
   assign irq_n = !st_reg.irq;

endmodule // ilbw_top

`default_nettype wire

//--- verif/ilbw_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ilbw_top_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic soft_reset,
   // Events
   input wire logic [15:0] hw_event,
   input wire logic [15:0] rt_event,
   input wire logic [15:0] rt_desc_addr,
   input wire logic term_busy,
   // Register bus and interrupt
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq_n
);
   wire logic req = avs_read | avs_write;
   wire logic ack_rd = avs_read & ~avs_waitrequest;
   // Bit 2 of the hardware events is a summary position and never counts as a cause.
   wire logic ev_any = |(hw_event & 16'hFFFB) | |rt_event;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_wait_idle; !req |-> !avs_waitrequest; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("stall without request");
   property p_wait_bound; req && avs_waitrequest |-> ##[1:2] !avs_waitrequest; endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("answer too late");
   property p_ack_single; req && !avs_waitrequest |=> !req || avs_waitrequest; endproperty
   a_ack_single: assert property (p_ack_single) else $error("double answer");
   property p_ptr_fmt;
      ack_rd && avs_address == 11'h028 |-> avs_readdata[8:6] == 3'b110 && !avs_readdata[0];
   endproperty
   a_ptr_fmt: assert property (p_ptr_fmt) else $error("pointer out of region");
   property p_hi_zero; ack_rd |-> avs_readdata[31:16] == 16'h0000; endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper lanes not zero");
   property p_unmapped; ack_rd && avs_address[10:2] == 9'h0FF |-> avs_readdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_irq_fall;
      $fell(irq_n) |-> $past(ev_any) || $past(ev_any, 2) || $past(avs_write)
         || $past(avs_write, 2) || $past(avs_write, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("request without event");
   property p_irq_rise;
      $rose(irq_n) |-> $past(avs_read) || $past(avs_read, 2) || $past(avs_write)
         || $past(avs_write, 2) || $past(avs_write, 3);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("request dropped alone");
endmodule // ilbw_top_chk
bind ilbw_top ilbw_top_chk u_ilbw_top_chk (.clock(clock), .rstn(rstn),
   .soft_reset(soft_reset), .hw_event(hw_event), .rt_event(rt_event),
   .rt_desc_addr(rt_desc_addr), .term_busy(term_busy), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq_n(irq_n));
`default_nettype wire

//--- verif/ilbw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ilbw_host_model (
   // Clock
   input wire logic clock,
   // Avalon master side
   output logic [10:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 11'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h3;
   end
   // Called just after a rising edge; the request stands until the rising edge at
   // which waitrequest is sampled low, and the slave's answer is taken at that edge.
   task automatic xfer(input logic wr, input logic [10:0] a, input logic [15:0] d);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {16'h0000, d};
      @(posedge clock);
      while (avs_waitrequest) @(posedge clock);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
endmodule // ilbw_host_model
`default_nettype wire

//--- verif/tb_ilbw_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
   $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module tb_ilbw_top;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic soft_reset = 1'b0;
   logic term_busy = 1'b0;
   logic [15:0] hw_event = 16'h0000;
   logic [15:0] rt_event = 16'h0000;
   logic [15:0] rt_desc_addr = 16'h0000;
   wire logic [10:0] avs_address;
   wire logic avs_read;
   wire logic avs_write;
   wire logic [31:0] avs_writedata;
   wire logic [3:0] avs_byteenable;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest;
   wire logic irq_n;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_ent = 0;
   int cnt = 0;
   logic [15:0] q[$];
   logic [15:0] lg[64];
   logic [15:0] id;
   logic [15:0] loc;
   logic [31:0] exp_rd;
   always #2 clock = ~clock;
   ilbw_top u_ilbw_top (.clock(clock), .rstn(rstn), .soft_reset(soft_reset),
      .hw_event(hw_event), .rt_event(rt_event), .rt_desc_addr(rt_desc_addr),
      .term_busy(term_busy), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_n(irq_n));
   ilbw_host_model u_ilbw_host_model (.clock(clock), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest));
   // Read data is taken at the rising edge that samples waitrequest low.
   always @(posedge clock) begin
      if (avs_read && !avs_waitrequest) begin
         exp_rd = {16'h0000, q.pop_front()};
         `CHK(avs_readdata, exp_rd)
      end
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [8:0] i, input logic [15:0] e);
      q.push_back(e);
      u_ilbw_host_model.xfer(1'b0, {i, 2'b00}, 16'h0000);
   endtask
   task automatic wr(input logic [8:0] i, input logic [15:0] d);
      u_ilbw_host_model.xfer(1'b1, {i, 2'b00}, d);
   endtask
   task automatic ev(input logic [15:0] h, input logic [15:0] r);
      hw_event <= h;
      rt_event <= r;
      @(posedge clock);
      hw_event <= 16'h0000;
      rt_event <= 16'h0000;
      repeat (5) @(posedge clock);
   endtask
   task automatic note(input logic [15:0] w0, input logic [15:0] w1);
      lg[2 * (n_ent % 32)] = w0;
      lg[2 * (n_ent % 32) + 1] = w1;
      n_ent++;
      if (cnt < 127) cnt++;
   endtask
   function automatic logic [15:0] exp_ptr();
      return {7'(cnt), 9'(9'h180 + 2 * (n_ent % 32))};
   endfunction
   initial begin
      void'($urandom(82));
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rd(9'h00A, 16'h0180);
      rd(9'h0FF, 16'h0000);
      foreach (lg[k]) lg[k] = 16'h0000;
      wr(9'h00F, 16'hFFFF);
      wr(9'h013, 16'hFFFF);
      wr(9'h040, 16'hFFFF);
      wr(9'h041, 16'hFFFF);
      wr(9'h04D, 16'h0004);
      wr(9'h00A, 16'h1234);
      rd(9'h00A, 16'h0180);
      rd(9'h04D, 16'h0004);
      $display("test reset and registers done");
      id = ($urandom() & 16'hFFF8) | 16'h0008;
      ev(id, 16'h0000);
      note(id, 16'h0000);
      `CHK(irq_n, 1'b0)
      rd(9'h180, id);
      rd(9'h181, 16'h0000);
      rd(9'h00A, exp_ptr());
      cnt = 0;
      rd(9'h006, id);
      rd(9'h006, 16'h0000);
      `CHK(irq_n, 1'b1)
      $display("test hardware entry done");
      id = ($urandom() & 16'hFDFF) | 16'h0011;
      loc = 16'($urandom());
      rt_desc_addr <= loc;
      term_busy <= 1'b1;
      ev(16'h0000, id);
      note(id | 16'h0200, loc);
      `CHK(irq_n, 1'b0)
      rd(9'h182, id | 16'h0200);
      rd(9'h183, loc);
      rd(9'h006, 16'h0004);
      rd(9'h009, id);
      repeat (10) @(posedge clock);
      rd(9'h00A, exp_ptr());
      cnt = 0;
      `CHK(irq_n, 1'b1)
      wr(9'h04D, 16'h0000);
      ev(16'h0000, 16'h0100);
      note(16'h0100, loc);
      rd(9'h184, 16'h0100);
      rd(9'h185, loc);
      rd(9'h009, 16'h0100);
      term_busy <= 1'b0;
      $display("test terminal entry done");
      wr(9'h00F, 16'h0000);
      ev(16'h8000, 16'h0000);
      wr(9'h00F, 16'hFFFF);
      repeat (6) @(posedge clock);
      rd(9'h006, 16'h0000);
      rd(9'h00A, exp_ptr());
      cnt = 0;
      $display("test disabled event done");
      repeat (160) begin
         id = ($urandom() & 16'hFFF8) | 16'h0008;
         ev(id, 16'h0000);
         note(id, 16'h0000);
         if (n_ent == 32) begin
            rd(9'h00A, exp_ptr());
            cnt = 0;
         end
      end
      rd(9'h00A, exp_ptr());
      for (int k = 0; k < 64; k += 5) rd(9'(9'h180 + k), lg[k]);
      $display("test wrap and saturation done");
      soft_reset <= 1'b1;
      @(posedge clock);
      soft_reset <= 1'b0;
      @(posedge clock);
      rd(9'h00A, 16'h0180);
      $display("test soft reset done");
      tally_and_finish();
   end
endmodule // tb_ilbw_top
`default_nettype wire
